// file: logic/host_port_extended_config.sv
// Top: host port extended config bank with AXI4-Lite read access
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Bits 15:8 pick pair buffer push-pull/open-drain
// - Bits 7:0 pick pair direction in/out
// - Fields reset zero, EEPROM default loaded
// - Bit 2 sets byte enable polarity
// - Bit 1 defers internal write to read
// - Bit 0 delays read acknowledge removal
// - Low byte at lowest address
module host_port_extended_config (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [1:0]   host_if_mode,
	input  wire logic         eeprom_load,
	input  wire logic [15:0]  eeprom_value,
	input  wire logic [5:0]   net_addr,
	output logic      [7:0]   net_rdata,
	output logic      [15:0]  io_open_drain,
	output logic      [15:0]  io_output_dir,
	output logic              byte_enable_pins_high,
	output logic              nonposted_write,
	output logic              read_ack_delay,
	input  wire logic [3:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic      [1:0]   s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [3:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic      [31:0]  s_axi_rdata,
	output logic      [1:0]   s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready
);
	cfg_load_if lp ();
	logic [15:0] view;
	logic        serial_mode;
	logic        aw_seen_reg, aw_seen_next;
	logic        w_seen_reg, w_seen_next;
	logic        bvalid_reg, bvalid_next;
	logic        rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic [7:0]  net_rdata_reg, net_rdata_next;
	logic [15:0] od_reg, od_next, dir_reg, dir_next;
	logic [2:0]  bus_reg, bus_next;

	assign lp.load = eeprom_load;
	assign lp.value = eeprom_value;

	cfg_store u_store (
		.aclk    (aclk),
		.aresetn (aresetn),
		.lp      (lp)
	);

	// One bit per pair fans out to both lines of the pair
	function automatic logic [15:0] pair_spread(input logic [7:0] b);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < host_port_cfg_pkg::PAIRS; i++) begin
			r[2*i]   = b[i];
			r[2*i+1] = b[i];
		end
		return r;
	endfunction : pair_spread

	assign serial_mode =
		host_if_mode == 2'(host_port_cfg_pkg::IF_SERIAL);

	// Same stored word, mode-specific view
	always_comb begin
		if (serial_mode) begin
			view = lp.cfg;
		end else begin
			view = lp.cfg & host_port_cfg_pkg::HOST_BUS_MASK;
		end
	end

	always_comb begin
		od_next = 16'h0000;
		dir_next = 16'h0000;
		bus_next = 3'h0;
		if (serial_mode) begin
			od_next = pair_spread(
				view[host_port_cfg_pkg::BUF_TYPE_LSB +: 8]);
			// Relies on the loader keeping these zero for bidirectional use
			dir_next = pair_spread(
				view[host_port_cfg_pkg::DIR_LSB +: 8]);
		end else begin
			// Polarity matters only for the mux and demux bus variants
			bus_next[2] = view[host_port_cfg_pkg::BE_POL_BIT] &&
				host_if_mode != 2'(host_port_cfg_pkg::IF_BUS_INDEXED);
			bus_next[1] = view[host_port_cfg_pkg::NONPOST_BIT];
			bus_next[0] = view[host_port_cfg_pkg::ACK_DELAY_BIT];
		end
	end

	// Network side reads bytes: low byte at address 0, high byte at 1, others read zero
	always_comb begin
		net_rdata_next = 8'h00;
		if (net_addr[5:1] == 5'h00) begin
			net_rdata_next = net_addr[0] ? view[15:8] : view[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			od_reg <= 16'h0000;
			dir_reg <= 16'h0000;
			bus_reg <= 3'h0;
			net_rdata_reg <= 8'h00;
		end else begin
			od_reg <= od_next;
			dir_reg <= dir_next;
			bus_reg <= bus_next;
			net_rdata_reg <= net_rdata_next;
		end
	end

	assign io_open_drain = od_reg;
	assign io_output_dir = dir_reg;
	assign byte_enable_pins_high = bus_reg[2];
	assign nonposted_write = bus_reg[1];
	assign read_ack_delay = bus_reg[0];
	assign net_rdata = net_rdata_reg;

	// Writes are accepted and refused: every field is read-only
	assign s_axi_awready = !aw_seen_reg && !bvalid_reg;
	assign s_axi_wready = !w_seen_reg && !bvalid_reg;
	always_comb begin
		aw_seen_next = aw_seen_reg || (s_axi_awvalid && s_axi_awready);
		w_seen_next = w_seen_reg || (s_axi_wvalid && s_axi_wready);
		bvalid_next = bvalid_reg;
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end else if (aw_seen_next && w_seen_next && !bvalid_reg) begin
			bvalid_next = 1'b1;
			aw_seen_next = 1'b0;
			w_seen_next = 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = host_port_cfg_pkg::RESP_SLVERR;

	assign s_axi_arready = !rvalid_reg;
	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rresp_next = host_port_cfg_pkg::RESP_OKAY;
			rdata_next = 32'h0000_0000;
			case (s_axi_araddr)
				host_port_cfg_pkg::OFF_SERIAL_CFG:
					rdata_next = {16'h0000, serial_mode ? view : 16'h0000};
				host_port_cfg_pkg::OFF_HOST_BUS_CFG:
					rdata_next = {16'h0000, serial_mode ? 16'h0000 : view};
				host_port_cfg_pkg::OFF_MODE:
					rdata_next = {30'h0, host_if_mode};
				host_port_cfg_pkg::OFF_LOAD:
					rdata_next = {16'h0000, lp.cfg};
				default:
					rresp_next = host_port_cfg_pkg::RESP_SLVERR;
			endcase
		end
	end
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_seen_reg <= 1'b0;
			w_seen_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= 2'h0;
		end else begin
			aw_seen_reg <= aw_seen_next;
			w_seen_reg <= w_seen_next;
			bvalid_reg <= bvalid_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	property p_od_pair;
		@(posedge aclk) disable iff (!aresetn)
		serial_mode |=> io_open_drain[15] == $past(lp.cfg[15])
			&& io_open_drain[0] == $past(lp.cfg[8]);
	endproperty
	a_od_pair: assert property (p_od_pair)
		else $error("buffer type pair mapping wrong");

	property p_dir_pair;
		@(posedge aclk) disable iff (!aresetn)
		serial_mode |=> io_output_dir[14] == $past(lp.cfg[7])
			&& io_output_dir[1] == $past(lp.cfg[0]);
	endproperty
	a_dir_pair: assert property (p_dir_pair)
		else $error("direction pair mapping wrong");

	property p_be_pol;
		@(posedge aclk) disable iff (!aresetn)
		!serial_mode
			&& host_if_mode != 2'(host_port_cfg_pkg::IF_BUS_INDEXED)
			|=> byte_enable_pins_high == $past(lp.cfg[2]);
	endproperty
	a_be_pol: assert property (p_be_pol)
		else $error("byte enable polarity wrong");

	// Indexed variant has no byte enables, so polarity must stay idle
	property p_be_indexed;
		@(posedge aclk) disable iff (!aresetn)
		host_if_mode == 2'(host_port_cfg_pkg::IF_BUS_INDEXED)
			|=> !byte_enable_pins_high;
	endproperty
	a_be_indexed: assert property (p_be_indexed)
		else $error("byte enable polarity set in indexed mode");

	property p_serial_bus_idle;
		@(posedge aclk) disable iff (!aresetn)
		serial_mode |=> !byte_enable_pins_high && !nonposted_write
			&& !read_ack_delay;
	endproperty
	a_serial_bus_idle: assert property (p_serial_bus_idle)
		else $error("bus layout outputs active in serial mode");

	property p_bus_io_idle;
		@(posedge aclk) disable iff (!aresetn)
		!serial_mode |=> io_open_drain == 16'h0000
			&& io_output_dir == 16'h0000;
	endproperty
	a_bus_io_idle: assert property (p_bus_io_idle)
		else $error("serial layout outputs active in bus mode");

	property p_nonpost;
		@(posedge aclk) disable iff (!aresetn)
		!serial_mode |=> nonposted_write == $past(lp.cfg[1]);
	endproperty
	a_nonpost: assert property (p_nonpost)
		else $error("write posting select wrong");

	property p_ack;
		@(posedge aclk) disable iff (!aresetn)
		!serial_mode |=> read_ack_delay == $past(lp.cfg[0]);
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack removal select wrong");

	property p_net_byte;
		@(posedge aclk) disable iff (!aresetn)
		net_addr == 6'h01 |=> net_rdata == $past(view[15:8]);
	endproperty
	a_net_byte: assert property (p_net_byte)
		else $error("byte order wrong");

	property p_net_low;
		@(posedge aclk) disable iff (!aresetn)
		net_addr == 6'h00 |=> net_rdata == $past(view[7:0]);
	endproperty
	a_net_low: assert property (p_net_low)
		else $error("low byte not at lowest address");

	property p_mode_view;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && !serial_mode
			&& s_axi_araddr == host_port_cfg_pkg::OFF_SERIAL_CFG
			|=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000;
	endproperty
	a_mode_view: assert property (p_mode_view)
		else $error("inactive layout visible");

	property p_reserved;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && s_axi_araddr == host_port_cfg_pkg::OFF_HOST_BUS_CFG
			&& !serial_mode |-> s_axi_rdata[15:3] == 13'h0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bits nonzero");

	property p_wr_refused;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> s_axi_bresp == host_port_cfg_pkg::RESP_SLVERR;
	endproperty
	a_wr_refused: assert property (p_wr_refused)
		else $error("write not refused");

	c_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
	c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
	c_serial_od: cover property (@(posedge aclk) io_open_drain != 16'h0);
	c_nonpost: cover property (@(posedge aclk) nonposted_write);
endmodule : host_port_extended_config
`default_nettype wire

// file: logic/host_port_cfg_pkg.sv
// Package: offsets, field positions and encodings of the host port config bank
`default_nettype none
package host_port_cfg_pkg;
	localparam int CFG_W = 16;
	localparam int PAIRS = 8;
	// Byte addresses on the AXI4-Lite slave
	localparam logic [3:0] OFF_SERIAL_CFG = 4'h0;
	localparam logic [3:0] OFF_HOST_BUS_CFG = 4'h4;
	localparam logic [3:0] OFF_MODE = 4'h8;
	localparam logic [3:0] OFF_LOAD = 4'hC;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam int BUF_TYPE_LSB = 8;
	localparam int DIR_LSB = 0;
	localparam int BE_POL_BIT = 2;
	localparam int NONPOST_BIT = 1;
	localparam int ACK_DELAY_BIT = 0;
	localparam logic [15:0] HOST_BUS_MASK = 16'h0007;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		IF_SERIAL,
		IF_BUS_MUX,
		IF_BUS_DEMUX,
		IF_BUS_INDEXED
	} host_if_mode_t;
endpackage : host_port_cfg_pkg
`default_nettype wire

// file: logic/cfg_load_if.sv
// Interface: start-up default load path into the config store
`timescale 1ns/1ns
`default_nettype none
interface cfg_load_if;
	logic        load;
	logic [15:0] value;
	logic [15:0] cfg;
	modport src (output load, output value, input cfg);
	modport store (input load, input value, output cfg);
endinterface : cfg_load_if
`default_nettype wire

// file: logic/cfg_store.sv
// Read-only config word that takes its default from the start-up loader
`timescale 1ns/1ns
`default_nettype none
module cfg_store (
	input  wire logic aclk,
	input  wire logic aresetn,
	cfg_load_if.store lp
);
	logic [15:0] cfg_reg;
	logic [15:0] cfg_next;

	always_comb begin
		cfg_next = cfg_reg;
		if (lp.load) begin
			cfg_next = lp.value;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg <= host_port_cfg_pkg::CFG_RESET;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	assign lp.cfg = cfg_reg;

	property p_load_takes;
		@(posedge aclk) disable iff (!aresetn)
		lp.load |=> cfg_reg == $past(lp.value);
	endproperty
	a_load_takes: assert property (p_load_takes)
		else $error("config default not loaded");

	property p_hold;
		@(posedge aclk) disable iff (!aresetn)
		!lp.load |=> $stable(cfg_reg);
	endproperty
	a_hold: assert property (p_hold)
		else $error("config changed without load");
endmodule : cfg_store
`default_nettype wire

// file: bench/eeprom_loader_model.sv
// Start-up EEPROM loader model feeding default words
`timescale 1ns/1ns
`default_nettype none
module eeprom_loader_model (
	input  wire logic        aclk,
	input  wire logic        start,
	input  wire logic        bidir,
	input  wire logic [15:0] word,
	output logic             load,
	output logic      [15:0] value
);
	logic [15:0] last;
	initial begin
		load = 1'b0;
		value = 16'hFFFF;
		last = 16'h0000;
	end
	always @(posedge aclk) begin
		load <= start;
		// Directions forced to input while lines run bidirectional
		last = bidir ? {word[15:8], 8'h00} : word;
		// Released bus shows garbage, never the last word
		value <= start ? last : ~last;
	end
endmodule : eeprom_loader_model
`default_nettype wire

// file: bench/host_port_extended_config_tb.sv
// Self-checking bench for the host port config bank
`timescale 1ns/1ns
`default_nettype none
module host_port_extended_config_tb;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [1:0]  mode = 2'h0;
	logic        start = 1'b0;
	logic        bidir = 1'b0;
	logic [15:0] word = 16'h0000;
	logic        ld;
	logic [15:0] ldv;
	logic [5:0]  na = 6'h00;
	logic [7:0]  nd;
	logic [15:0] od, dir;
	logic        bep, npw, ackd;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [15:0] w;
	int          err_total = 0;
	int          tests_run = 0;
	always #5 aclk = ~aclk;
	eeprom_loader_model ee (.aclk(aclk), .start(start), .bidir(bidir),
		.word(word), .load(ld), .value(ldv));
	host_port_extended_config dut (.aclk(aclk), .aresetn(aresetn),
		.host_if_mode(mode), .eeprom_load(ld), .eeprom_value(ldv),
		.net_addr(na), .net_rdata(nd), .io_open_drain(od),
		.io_output_dir(dir), .byte_enable_pins_high(bep),
		.nonposted_write(npw), .read_ack_delay(ackd),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1));
	task automatic stop_test;
		$display("Mismatches %0d, checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One edge per call, so a hang is cut after a bounded count
	task automatic step(inout int n);
		@(posedge aclk);
		n++;
		if (n > 20) begin
			err_total++;
			stop_test();
		end
	endtask : step
	task automatic rd(input logic [3:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do step(n); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do step(n); while (rvalid !== 1'b1);
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rd
	// Every write is refused with SLVERR
	task automatic wr(input logic [3:0] a);
		int n;
		logic aw, wd;
		n = 0;
		aw = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= 32'hFFFFFFFF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && wd)) begin
			step(n);
			if (!aw && awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do step(n); while (bvalid !== 1'b1);
		chk({30'h0, bresp}, {30'h0, host_port_cfg_pkg::RESP_SLVERR});
	endtask : wr
	task automatic load(input logic [15:0] v);
		word <= v;
		start <= 1'b1;
		@(posedge aclk);
		start <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask : load
	function automatic logic [15:0] pairs(input logic [7:0] b);
		logic [15:0] r;
		for (int k = 0; k < 8; k++) r[2*k +: 2] = {2{b[k]}};
		return r;
	endfunction : pairs
	task automatic net(input logic [5:0] a, input logic [7:0] e);
		na <= a;
		repeat (2) @(posedge aclk);
		chk({24'h0, nd}, {24'h0, e});
	endtask : net
	task automatic after_reset;
		rd(4'h0, 32'h0, host_port_cfg_pkg::RESP_OKAY);
		rd(4'hC, 32'h0, host_port_cfg_pkg::RESP_OKAY);
		chk({od, dir}, 32'h0);
	endtask : after_reset
	task automatic serial_view;
		load(w);
		chk({16'h0, od}, {16'h0, pairs(w[15:8])});
		chk({16'h0, dir}, {16'h0, pairs(w[7:0])});
		rd(4'h0, {16'h0, w}, host_port_cfg_pkg::RESP_OKAY);
		rd(4'h4, 32'h0, host_port_cfg_pkg::RESP_OKAY);
		net(6'h00, w[7:0]);
		net(6'h01, w[15:8]);
		net(6'h02, 8'h00);
	endtask : serial_view
	task automatic bus_modes;
		for (int m = 1; m < 4; m++) begin
			mode <= 2'(m);
			repeat (3) @(posedge aclk);
			chk({31'h0, bep}, {31'h0, w[2] && m != 3});
			chk({31'h0, npw}, {31'h0, w[1]});
			chk({31'h0, ackd}, {31'h0, w[0]});
			chk({od, dir}, 32'h0);
			rd(4'h4, {29'h0, w[2:0]}, host_port_cfg_pkg::RESP_OKAY);
			rd(4'h0, 32'h0, host_port_cfg_pkg::RESP_OKAY);
			rd(4'h8, 32'(m), host_port_cfg_pkg::RESP_OKAY);
		end
		mode <= 2'h0;
	endtask : bus_modes
	task automatic refused;
		wr(4'hC);
		wr(4'h0);
		rd(4'hC, {16'h0, w}, host_port_cfg_pkg::RESP_OKAY);
		rd(4'h2, 32'h0, host_port_cfg_pkg::RESP_SLVERR);
	endtask : refused
	task automatic bidir_load;
		bidir <= 1'b1;
		load(16'hFFFF);
		chk({od, dir}, 32'hFFFF0000);
		bidir <= 1'b0;
	endtask : bidir_load
	initial begin
		w = 16'hA5C5;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		after_reset();
		serial_view();
		bus_modes();
		// Flipped word so every field bit is seen at both levels
		w = ~w;
		serial_view();
		bus_modes();
		refused();
		bidir_load();
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		after_reset();
		stop_test();
	end
endmodule : host_port_extended_config_tb
`default_nettype wire
